// [verilog/ffm_pkg.sv]
// Constants and types of the fault flag monitor
package ffm_pkg;
  // ****************************************
  // Register map
  // ****************************************
  localparam logic [3:0] ADDR_FAULT = 4'h0;
  localparam logic [3:0] ADDR_CAUTION = 4'h1;
  localparam logic [3:0] ADDR_FAULT_MASK = 4'h2;
  localparam logic [3:0] ADDR_CAUTION_MASK = 4'h3;
  localparam logic [3:0] ADDR_CONFIG = 4'h4;
  localparam logic [3:0] ADDR_PWM_EN = 4'h5;
  localparam logic [3:0] ADDR_POSITION = 4'h6;
  localparam logic [3:0] ADDR_CLEAR = 4'h7;
  localparam int NUM_FAULT = 9;
  localparam int NUM_CAUTION = 8;
  // Fault bit positions
  localparam int F_SUPPLY = 0;
  localparam int F_FIELD_LOW = 1;
  localparam int F_OSC = 2;
  localparam int F_EE_FATAL = 3;
  localparam int F_ZERO_X = 4;
  localparam int F_LOCK = 5;
  localparam int F_POWER = 6;
  localparam int F_QUAD = 7;
  localparam int F_REG = 8;
  localparam int F_MEAN = 8 + 1;
  // Caution bit positions
  localparam int C_FIELD_HIGH = 0;
  localparam int C_TEMP = 1;
  localparam int C_EE_FIX = 2;
  localparam int C_TURN_SAT = 3;
  localparam int C_TURN_SPEED = 4;
  localparam int C_FRAME = 5;
  localparam int C_CHECKSUM = 6;
  localparam int C_SPARE = 7;
  // Config fields
  localparam int CFG_LO_LSB = 0;
  localparam int CFG_HI_LSB = 6;
  localparam int CFG_PWM_EN = 12;
  localparam int CFG_PWM_STYLE = 13;
  localparam int CFG_CHK_EN = 14;
  localparam logic [5:0] THRES_HI_RST = 6'h25;
  localparam logic [5:0] THRES_LO_RST = 6'h0d;
  localparam logic [15:0] CONFIG_RST = {4'h0, THRES_HI_RST, THRES_LO_RST};
  localparam int FIELD_HI_STEP_G = 32;
  localparam int FIELD_LO_STEP_G = 16;
  localparam int TURN_LIMIT = 256;
  localparam int TEMP_MIN_C = -60;
  localparam int TEMP_MAX_C = 180;
  localparam int SPAN_QUAD_MAX = 2;
  localparam logic [11:0] ANGLE_135 = 12'h600;
  // Pwm priority codes, 1 highest
  localparam int NUM_PRIO = 12;
  typedef enum logic [1:0] {
    FFM_PWM_NORMAL = 2'b00,
    FFM_PWM_TRISTATE = 2'b01,
    FFM_PWM_DUTY = 2'b10
  } ffm_pwm_mode_t;
  // Duty per priority in thousandths: 5 .. 72.5 percent, skipped codes kept
  localparam logic [9:0] DUTY_TABLE [0:12] = '{
    10'd50, 10'd106, 10'd163, 10'd219, 10'd275, 10'd331, 10'd388,
    10'd444, 10'd500, 10'd556, 10'd613, 10'd669, 10'd725};
endpackage : ffm_pkg

// [verilog/ffm_monitor.sv]
// Fault and caution flag monitor with pwm fault reporting
`timescale 1ns/1ps
`default_nettype none
module ffm_monitor #(
  parameter int ANGLE_W = 12
) (
  input  wire logic                  core_clk,
  input  wire logic                  rst_n,
  input  wire logic                  supply_low_raw,
  input  wire logic                  reg_drift_raw,
  input  wire logic                  osc_mismatch_raw,
  input  wire logic                  lock_lost_raw,
  input  wire logic                  zero_cross_diff_raw,
  input  wire logic                  temp_range_raw,
  input  wire logic [10:0]           field_gauss,
  input  wire logic                  ee_corrected_ev,
  input  wire logic                  ee_fatal_ev,
  input  wire logic                  power_restored_ev,
  input  wire logic [1:0]            quad_state,
  input  wire logic                  turns_update_ev,
  input  wire logic [8:0]            turns_count,
  input  wire logic [ANGLE_W-1:0]    angle,
  input  wire logic                  avg_sample_ev,
  input  wire logic                  avg_period_end_ev,
  input  wire logic                  frame_done_ev,
  input  wire logic [5:0]            frame_edges,
  input  wire logic                  frame_first_bit,
  input  wire logic                  frame_is_20bit,
  input  wire logic                  frame_crc_ok,
  input  wire logic [3:0]            addr,
  input  wire logic [15:0]           wdata,
  input  wire logic                  wr_en,
  input  wire logic                  rd_en,
  output logic      [15:0]           rdata,
  output logic                       general_fault_flag,
  output logic                       low_supply_any_flag,
  output logic                       pwm_tristate,
  output logic                       pwm_half_carrier,
  output logic      [9:0]            pwm_fault_duty
);
  import ffm_pkg::*;

  initial begin
    if (ANGLE_W != 12) $error("ffm_monitor: ANGLE_W must be 12");
  end

  // ****************************************
  // Pin synchronisers
  // ****************************************
  localparam int NSYNC = 6;
  logic [NSYNC-1:0] sync_a;
  logic [NSYNC-1:0] sync_b;
  wire  [NSYNC-1:0] raw_in = {temp_range_raw, zero_cross_diff_raw, lock_lost_raw,
                              osc_mismatch_raw, reg_drift_raw, supply_low_raw};
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_a <= '0;
      sync_b <= '0;
    end else begin
      sync_a <= raw_in;
      sync_b <= sync_a;
    end
  end

  // ****************************************
  // Configuration
  // ****************************************
  logic [15:0] config_reg;
  logic [NUM_FAULT:0] fault_mask;
  logic [NUM_CAUTION-1:0] caution_mask;
  logic [15:0] pwm_enable;
  wire [5:0] thres_lo = config_reg[CFG_LO_LSB +: 6];
  wire [5:0] thres_hi = config_reg[CFG_HI_LSB +: 6];
  wire pwm_fault_enable_bit = config_reg[CFG_PWM_EN];
  wire pwm_fault_style_bit = config_reg[CFG_PWM_STYLE];
  wire checksum_check_enable = config_reg[CFG_CHK_EN];

  // ****************************************
  // Detectors
  // ****************************************
  wire [11:0] field_w = {1'b0, field_gauss};
  wire [11:0] hi_lim = 12'(thres_hi * FIELD_HI_STEP_G);
  wire [11:0] lo_lim = 12'(thres_lo * FIELD_LO_STEP_G);
  wire field_high_det = (thres_hi != 6'h00) && (field_w > hi_lim);
  wire field_low_det = (thres_lo != 6'h00) && (field_w < lo_lim);

  logic [1:0] quad_prev;
  wire [1:0] quad_gray_prev = {quad_prev[1], quad_prev[1] ^ quad_prev[0]};
  wire [1:0] quad_gray_now = {quad_state[1], quad_state[1] ^ quad_state[0]};
  wire [1:0] quad_step = quad_gray_now - quad_gray_prev;
  wire quad_skip_det = (quad_step == 2'h2);

  logic [11:0] turn_angle;
  wire [11:0] turn_delta = angle - turn_angle;
  wire [11:0] turn_mag = turn_delta[11] ? 12'(-turn_delta) : turn_delta;
  wire turn_speed_det = turns_update_ev && (turn_mag > ANGLE_135);
  wire turn_sat_det = turns_count >= 9'(TURN_LIMIT);

  logic [3:0] quad_seen;
  wire [3:0] quad_seen_next = quad_seen | (4'h1 << angle[11:10]);
  wire [2:0] quad_cnt = 3'(quad_seen_next[0]) + 3'(quad_seen_next[1])
                      + 3'(quad_seen_next[2]) + 3'(quad_seen_next[3]);
  wire mean_span_det = avg_period_end_ev && (quad_cnt > 3'(SPAN_QUAD_MAX));

  wire bad_frame_det = frame_done_ev &&
                       (((frame_edges != 6'd16) && (frame_edges != 6'd20))
                        || frame_first_bit);
  wire checksum_det = frame_done_ev && frame_is_20bit && checksum_check_enable
                      && !frame_crc_ok;

  logic [NUM_FAULT:0] fault_set;
  logic [NUM_CAUTION-1:0] caution_set;
  always_comb begin
    fault_set = '0;
    fault_set[F_SUPPLY] = sync_b[0];
    fault_set[F_REG] = sync_b[1];
    fault_set[F_OSC] = sync_b[2];
    fault_set[F_LOCK] = sync_b[3];
    fault_set[F_ZERO_X] = sync_b[4];
    fault_set[F_FIELD_LOW] = field_low_det;
    fault_set[F_EE_FATAL] = ee_fatal_ev;
    fault_set[F_POWER] = power_restored_ev;
    fault_set[F_QUAD] = quad_skip_det;
    fault_set[F_MEAN] = mean_span_det;
    caution_set = '0;
    caution_set[C_FIELD_HIGH] = field_high_det;
    caution_set[C_TEMP] = sync_b[5];
    caution_set[C_EE_FIX] = ee_corrected_ev;
    caution_set[C_TURN_SAT] = turn_sat_det;
    caution_set[C_TURN_SPEED] = turn_speed_det;
    caution_set[C_FRAME] = bad_frame_det;
    caution_set[C_CHECKSUM] = checksum_det;
  end

  // ****************************************
  // Sticky flags, set wins over clear
  // ****************************************
  logic [NUM_FAULT:0] fault_reg;
  logic [NUM_CAUTION-1:0] caution_reg;
  wire clr_wr = wr_en && (addr == ADDR_CLEAR);
  wire [NUM_FAULT:0] fault_clr = clr_wr ? wdata[NUM_FAULT:0] : '0;
  wire [NUM_CAUTION-1:0] caution_clr = (wr_en && addr == ADDR_CAUTION)
                                       ? wdata[NUM_CAUTION-1:0] : '0;
  wire [NUM_FAULT:0] next_fault = (fault_reg & ~fault_clr) | fault_set;
  wire [NUM_CAUTION-1:0] next_caution = (caution_reg & ~caution_clr) | caution_set;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      fault_reg <= '0;
      caution_reg <= '0;
      quad_prev <= 2'h0;
      turn_angle <= 12'h000;
      quad_seen <= 4'h0;
    end else begin
      fault_reg <= next_fault;
      caution_reg <= next_caution;
      quad_prev <= quad_state;
      if (turns_update_ev) turn_angle <= angle;
      if (avg_period_end_ev) quad_seen <= 4'h0;
      else if (avg_sample_ev) quad_seen <= quad_seen_next;
    end
  end

  // ****************************************
  // Angle word flags
  // ****************************************
  wire [NUM_FAULT:0] fault_live = fault_reg & ~fault_mask;
  wire [NUM_CAUTION-1:0] caution_live = caution_reg & ~caution_mask;
  wire next_general = |fault_live | |caution_live;
  wire next_low_supply = fault_live[F_SUPPLY] | fault_live[F_REG];

  // ****************************************
  // Pwm fault report
  // ****************************************
  // Priority order 1..13; slots 3 and 10 unused here, turn saturation at 13
  logic [12:0] prio_vec;
  always_comb begin
    prio_vec = '0;
    prio_vec[0] = fault_reg[F_OSC];
    prio_vec[1] = fault_reg[F_EE_FATAL];
    prio_vec[3] = fault_reg[F_LOCK];
    prio_vec[4] = fault_reg[F_ZERO_X];
    prio_vec[5] = fault_reg[F_MEAN];
    prio_vec[6] = next_low_supply;
    prio_vec[7] = fault_reg[F_FIELD_LOW];
    prio_vec[8] = caution_reg[C_EE_FIX];
    prio_vec[10] = caution_reg[C_FIELD_HIGH];
    prio_vec[11] = caution_reg[C_TEMP];
    prio_vec[12] = caution_reg[C_TURN_SAT];
  end
  wire [12:0] prio_on = prio_vec & pwm_enable[12:0];

  logic [9:0] sel_duty;
  always_comb begin
    sel_duty = 10'h000;
    for (int i = 12; i >= 0; i--) begin
      if (prio_on[i]) sel_duty = DUTY_TABLE[i];
    end
  end

  ffm_pwm_mode_t next_mode;
  always_comb begin
    if (!pwm_fault_enable_bit || prio_on == '0) next_mode = FFM_PWM_NORMAL;
    else if (!pwm_fault_style_bit) next_mode = FFM_PWM_TRISTATE;
    else next_mode = FFM_PWM_DUTY;
  end

  ffm_pwm_mode_t pwm_mode;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pwm_mode <= FFM_PWM_NORMAL;
      pwm_fault_duty <= 10'h000;
      general_fault_flag <= 1'b0;
      low_supply_any_flag <= 1'b0;
    end else begin
      pwm_mode <= next_mode;
      pwm_fault_duty <= (next_mode == FFM_PWM_DUTY) ? sel_duty : 10'h000;
      general_fault_flag <= next_general;
      low_supply_any_flag <= next_low_supply;
    end
  end

  always_comb begin
    case (pwm_mode)
      FFM_PWM_TRISTATE: begin
        pwm_tristate = 1'b1;
        pwm_half_carrier = 1'b0;
      end
      FFM_PWM_DUTY: begin
        pwm_tristate = 1'b0;
        pwm_half_carrier = 1'b1;
      end
      default: begin
        pwm_tristate = 1'b0;
        pwm_half_carrier = 1'b0;
      end
    endcase
  end

  // ****************************************
  // Register port
  // ****************************************
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      config_reg <= CONFIG_RST;
      fault_mask <= '0;
      caution_mask <= '0;
      pwm_enable <= 16'h0000;
    end else if (wr_en) begin
      if (addr == ADDR_CONFIG) config_reg <= {1'b0, wdata[14:0]};
      if (addr == ADDR_FAULT_MASK) fault_mask <= wdata[NUM_FAULT:0];
      if (addr == ADDR_CAUTION_MASK) caution_mask <= wdata[NUM_CAUTION-1:0];
      if (addr == ADDR_PWM_EN) pwm_enable <= {3'h0, wdata[12:0]};
    end
  end

  logic [15:0] rd_mux;
  always_comb begin
    case (addr)
      ADDR_FAULT:        rd_mux = 16'(fault_reg);
      ADDR_CAUTION:      rd_mux = 16'(caution_reg);
      ADDR_FAULT_MASK:   rd_mux = 16'(fault_mask);
      ADDR_CAUTION_MASK: rd_mux = 16'(caution_mask);
      ADDR_CONFIG:       rd_mux = config_reg;
      ADDR_PWM_EN:       rd_mux = pwm_enable;
      ADDR_POSITION:     rd_mux = {general_fault_flag, low_supply_any_flag, 2'h0, angle};
      default:           rd_mux = 16'h0000;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) rdata <= 16'h0000;
    else if (rd_en) rdata <= rd_mux;
    else rdata <= 16'h0000;
  end
endmodule : ffm_monitor
`default_nettype wire

// [sim/ffm_monitor_properties.sv]
// Port checker of the fault flag monitor
`timescale 1ns/1ps
`default_nettype none
module ffm_monitor_properties (
  input wire logic        core_clk,
  input wire logic        rst_n,
  input wire logic        supply_low_raw,
  input wire logic        reg_drift_raw,
  input wire logic        ee_corrected_ev,
  input wire logic        ee_fatal_ev,
  input wire logic        power_restored_ev,
  input wire logic        rd_en,
  input wire logic [15:0] rdata,
  input wire logic        general_fault_flag,
  input wire logic        low_supply_any_flag,
  input wire logic        pwm_tristate,
  input wire logic        pwm_half_carrier,
  input wire logic [9:0]  pwm_fault_duty
);
  // ****************************************
  // Checks
  // ****************************************
  // Sync latency is two flops plus the sticky register and the flag register
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  a_supply_sets_uv: assert property (supply_low_raw [*4] |-> ##[0:2] low_supply_any_flag)
    else $error("supply low not flagged");
  a_drift_sets_uv: assert property (reg_drift_raw [*4] |-> ##[0:2] low_supply_any_flag)
    else $error("regulator drift not flagged");
  a_fix_sets_general: assert property (ee_corrected_ev |-> ##[1:4] general_fault_flag)
    else $error("corrected error not in general flag");
  a_fatal_sets_general: assert property (ee_fatal_ev |-> ##[1:4] general_fault_flag)
    else $error("fatal error not in general flag");
  a_power_sets_general: assert property (power_restored_ev |-> ##[1:4] general_fault_flag)
    else $error("power loss not in general flag");
  a_read_idle_zero: assert property (!$past(rd_en) |-> rdata == 16'h0)
    else $error("read data outside answer cycle");
  a_modes_exclusive: assert property (pwm_tristate |-> !pwm_half_carrier)
    else $error("tristate and duty mode together");
  a_duty_needs_half: assert property (pwm_fault_duty != 10'h0 |-> pwm_half_carrier)
    else $error("duty without half carrier");
  a_duty_in_range: assert property (pwm_half_carrier |-> pwm_fault_duty inside {[50:725]})
    else $error("duty outside table");
endmodule : ffm_monitor_properties
`default_nettype wire

// [sim/ffm_host.sv]
// Host model driving the register port
`timescale 1ns/1ps
`default_nettype none
module ffm_host (
  input  wire logic        core_clk,
  output logic      [3:0]  addr,
  output logic      [15:0] wdata,
  output logic             wr_en,
  output logic             rd_en,
  input  wire logic [15:0] rdata
);
  // ****************************************
  // Bus cycles
  // ****************************************
  initial begin
    addr = 4'h0;
    wdata = 16'h0;
    wr_en = 1'b0;
    rd_en = 1'b0;
  end
  // Released lines show inverted value, not the last one
  task wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge core_clk);
    addr <= a;
    wdata <= v;
    wr_en <= 1'b1;
    @(posedge core_clk);
    wr_en <= 1'b0;
    addr <= ~a;
    wdata <= ~v;
  endtask : wr
  task rd(input logic [3:0] a, output logic [15:0] v);
    @(posedge core_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge core_clk);
    rd_en <= 1'b0;
    addr <= ~a;
    @(negedge core_clk);
    v = rdata;
  endtask : rd
endmodule : ffm_host
`default_nettype wire

// [sim/tb_top.sv]
// Testbench of the fault flag monitor
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import ffm_pkg::*;
  logic            core_clk, rst_n, fb, f20, crc;
  logic [5:0]      lv, edges;
  logic [6:0]      ev;
  logic [10:0]     field;
  logic [1:0]      quad;
  logic [8:0]      turns;
  logic [11:0]     angle;
  logic [15:0]     d;
  wire logic [3:0] addr;
  wire logic [15:0] wdata, rdata;
  wire logic       wr_en, rd_en, gf, lsf, tri_o, half;
  wire logic [9:0] duty;
  int              n_fail, checks;
  int              fp [0:4] = '{F_SUPPLY, F_REG, F_OSC, F_LOCK, F_ZERO_X};
  logic [10:0]     fv [0:3] = '{11'd1185, 11'd1184, 11'd207, 11'd208};
  ffm_host i_ffm_host (.core_clk(core_clk), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata(rdata));
  ffm_monitor i_ffm_monitor (.core_clk(core_clk), .rst_n(rst_n), .supply_low_raw(lv[0]),
    .reg_drift_raw(lv[1]), .osc_mismatch_raw(lv[2]), .lock_lost_raw(lv[3]),
    .zero_cross_diff_raw(lv[4]), .temp_range_raw(lv[5]), .field_gauss(field),
    .ee_corrected_ev(ev[0]), .ee_fatal_ev(ev[1]), .power_restored_ev(ev[2]),
    .quad_state(quad), .turns_update_ev(ev[3]), .turns_count(turns), .angle(angle),
    .avg_sample_ev(ev[5]), .avg_period_end_ev(ev[6]), .frame_done_ev(ev[4]),
    .frame_edges(edges), .frame_first_bit(fb), .frame_is_20bit(f20), .frame_crc_ok(crc),
    .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
    .general_fault_flag(gf), .low_supply_any_flag(lsf), .pwm_tristate(tri_o),
    .pwm_half_carrier(half), .pwm_fault_duty(duty));
  // ****************************************
  // Tasks
  // ****************************************
  task stop_test;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : stop_test
  task chk(input logic [15:0] s, input logic [15:0] e);
    checks++;
    if (s !== e) begin
      n_fail++;
      $display("mismatch at %0t: saw %h want %h", $time, s, e);
    end
  endtask : chk
  task cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask : cyc
  task rchk(input logic [3:0] a, input logic [15:0] e);
    i_ffm_host.rd(a, d);
    chk(d, e);
  endtask : rchk
  task clr;
    i_ffm_host.wr(ADDR_CLEAR, 16'hffff);
    i_ffm_host.wr(ADDR_CAUTION, 16'hffff);
    cyc(3);
  endtask : clr
  // Reads both flag words, then clears and expects a quiet general flag
  task flags(input logic [15:0] f, input logic [15:0] c);
    rchk(ADDR_FAULT, f);
    rchk(ADDR_CAUTION, c);
    chk(gf, |{f, c});
    clr;
    chk(gf, 16'h0);
  endtask : flags
  task pulse(input int b);
    @(posedge core_clk);
    ev <= 7'h1 << b;
    @(posedge core_clk);
    ev <= 7'h0;
    cyc(3);
  endtask : pulse
  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  initial begin
    #400000;
    n_fail++;
    stop_test();
  end
  initial begin
    {rst_n, fb, f20, crc, lv, ev, quad, turns, angle} = '0;
    field = 11'd600;
    edges = 6'd16;
    crc = 1'b1;
    n_fail = 0;
    checks = 0;
    cyc(20);
    rst_n <= 1'b1;
    cyc(2);
    rchk(ADDR_CONFIG, CONFIG_RST);
    rchk(4'hf, 16'h0);
    rchk(ADDR_FAULT_MASK, 16'h0);
    for (int i = 0; i < 6; i++) begin
      lv <= 6'h1 << i;
      cyc(6);
      chk(lsf, i < 2);
      lv <= 6'h0;
      flags(i < 5 ? 16'h1 << fp[i] : 16'h0, i == 5 ? 16'h1 << C_TEMP : 16'h0);
    end
    for (int i = 0; i < 3; i++) begin
      pulse(i);
      flags(i == 1 ? 16'h1 << F_EE_FATAL : i == 2 ? 16'h1 << F_POWER : 16'h0,
            i == 0 ? 16'h1 << C_EE_FIX : 16'h0);
    end
    for (int i = 0; i < 4; i++) begin
      field <= fv[i];
      cyc(4);
      field <= 11'd600;
      flags(i == 2 ? 16'h1 << F_FIELD_LOW : 16'h0, i == 0 ? 16'h1 << C_FIELD_HIGH : 16'h0);
    end
    quad <= 2'b11;
    cyc(3);
    quad <= 2'b10;
    cyc(1);
    quad <= 2'b00;
    flags(16'h1 << F_QUAD, 16'h0);
    for (int i = 0; i < 3; i++) begin
      angle <= 12'(12'h100 + 12'h400 * i);
      pulse(5);
    end
    pulse(6);
    flags(16'h1 << F_MEAN, 16'h0);
    angle <= 12'h0;
    pulse(3);
    clr;
    angle <= 12'h601;
    pulse(3);
    flags(16'h0, 16'h1 << C_TURN_SPEED);
    turns <= 9'd256;
    pulse(3);
    turns <= 9'd0;
    flags(16'h0, 16'h1 << C_TURN_SAT);
    edges <= 6'd17;
    pulse(4);
    flags(16'h0, 16'h1 << C_FRAME);
    edges <= 6'd16;
    fb <= 1'b1;
    pulse(4);
    flags(16'h0, 16'h1 << C_FRAME);
    {fb, f20, crc, edges} <= {3'b010, 6'd20};
    pulse(4);
    flags(16'h0, 16'h0);
    i_ffm_host.wr(ADDR_CONFIG, CONFIG_RST | 16'h1 << CFG_CHK_EN);
    pulse(4);
    flags(16'h0, 16'h1 << C_CHECKSUM);
    i_ffm_host.wr(ADDR_FAULT_MASK, 16'h1 << F_OSC);
    lv <= 6'h4;
    cyc(6);
    chk(gf, 16'h0);
    rchk(ADDR_FAULT, 16'h1 << F_OSC);
    rchk(ADDR_POSITION, 16'h0601);
    i_ffm_host.wr(ADDR_FAULT_MASK, 16'h0);
    i_ffm_host.wr(ADDR_PWM_EN, 16'h1fff);
    i_ffm_host.wr(ADDR_CONFIG, CONFIG_RST);
    cyc(3);
    chk({tri_o, half}, 16'h0);
    i_ffm_host.wr(ADDR_CONFIG, CONFIG_RST | 16'h1 << CFG_PWM_EN);
    cyc(3);
    chk({tri_o, half}, 16'h2);
    i_ffm_host.wr(ADDR_CONFIG, CONFIG_RST | 16'h3 << CFG_PWM_EN);
    cyc(3);
    chk({tri_o, half}, 16'h1);
    chk(duty, DUTY_TABLE[0]);
    i_ffm_host.wr(ADDR_PWM_EN, 16'h2);
    pulse(1);
    chk(duty, DUTY_TABLE[1]);
    i_ffm_host.wr(ADDR_PWM_EN, 16'h0);
    cyc(3);
    chk(duty, 16'h0);
    lv <= 6'h0;
    i_ffm_host.wr(ADDR_CONFIG, CONFIG_RST);
    clr;
    stop_test();
  end
endmodule : tb_top
bind ffm_monitor ffm_monitor_properties i_ffm_monitor_properties (.core_clk(core_clk),
  .rst_n(rst_n), .supply_low_raw(supply_low_raw), .reg_drift_raw(reg_drift_raw),
  .ee_corrected_ev(ee_corrected_ev), .ee_fatal_ev(ee_fatal_ev),
  .power_restored_ev(power_restored_ev), .rd_en(rd_en), .rdata(rdata),
  .general_fault_flag(general_fault_flag), .low_supply_any_flag(low_supply_any_flag),
  .pwm_tristate(pwm_tristate), .pwm_half_carrier(pwm_half_carrier),
  .pwm_fault_duty(pwm_fault_duty));
`default_nettype wire
